// [pm_pkg.sv]
// constants and carrier types for the power manager clock gate / reset origin block
package pm_pkg;

   // register offsets (byte addresses)
   localparam logic [7:0] DIV_SEL_OFS = 8'h08;
   localparam logic [7:0] EVT_STAT_OFS = 8'h0c;
   localparam logic [7:0] EVT_MASK_OFS = 8'h0d;
   localparam logic [7:0] BUS_C_MASK_OFS = 8'h20;
   localparam logic [7:0] IRQ_EN_CLR_OFS = 8'h34;
   localparam logic [7:0] IRQ_EN_SET_OFS = 8'h35;
   localparam logic [7:0] IRQ_FLAG_OFS = 8'h36;
   localparam logic [7:0] RESET_ORIGIN_OFS = 8'h38;

   // field positions
   localparam int CLOCK_READY_BIT = 0;
   localparam int GATE_BITS = 4;
   localparam int CPU_SEL_LSB = 0;
   localparam int BUS_SEL_LSB = 4;
   localparam int SEL_W = 3;
   localparam int EVT_W = 3;
   localparam int EVT_CLOCK_READY = 0;
   localparam int EVT_ORIGIN_CAPTURED = 1;
   localparam int EVT_GATE_CHANGED = 2;

   // reset values
   localparam logic [3:0] BUS_C_MASK_RST = 4'h0;
   localparam logic [7:0] RESET_ORIGIN_RST = 8'h01;
   localparam logic [2:0] SEL_RST = 3'h0;
   localparam logic [2:0] EVT_RST = 3'h0;

   // divider settling time after a new selection
   localparam int SETTLE_NS = 40;
   localparam int CLK_PERIOD_PS = 4000;
   localparam int SETTLE_CYC = (SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam logic [4:0] SETTLE_CNT = 5'(SETTLE_CYC);

   // reset sources as reported by the reset controller
   typedef struct packed {
      logic sys_request;
      logic watchdog;
      logic pin;
      logic brownout_io;
      logic brownout_core;
      logic power_on;
   } reset_src_t;

   // divider selections driven out to the clock generator
   typedef struct packed {
      logic [2:0] bus_clock_divider_sel;
      logic [2:0] cpu_clock_divider_sel;
   } div_sel_t;

endpackage

// [pm_clock_gate_irq_reset_cause.sv]
// peripheral bus c clock gates, clock-ready interrupt and reset origin capture
//
// Behaviour
// - gate bits 3..0 stop their peripheral bus clock at 0, run at 1
// - writing one to bit 0 at 0x34 clears enable and withdraws request
// - writing one to bit 0 at 0x35 sets the clock-ready interrupt enable
// - writing zero to clock-ready bits of 0x34/0x35/0x36 changes nothing
// - request asserted while enabled and flag set, never while disabled
// - clock-ready flag sets once clocks reach the selected divider frequencies
// - clock-ready flag at 0x36 clears on writing one, resets to zero
// - reset origin at 0x38 is read-only, resets 0x01, bit 0 marks power-on
// - reset origin bit 6 marks a processor system reset request
// - reset origin bit 5 marks a watchdog reset
// - reset origin bit 4 marks an external reset pin reset
// - reset origin bit 2 marks an io-supply brown-out reset
// - reset origin bit 1 marks a core-supply brown-out reset
module pm_clock_gate_irq_reset_cause (
   input wire logic clk,                          // bus clock, 250 MHz
   input wire logic srst,                         // synchronous reset, active high
   input wire logic [7:0] addr,                   // register byte address
   input wire logic [31:0] wdata,                 // write data
   input wire logic wr,                           // write strobe
   input wire logic rd,                           // read strobe
   output logic [31:0] rdata,                     // read data, cycle after rd
   input wire pm_pkg::reset_src_t reset_src,      // reset causes, asynchronous levels
   output pm_pkg::div_sel_t div_sel,              // divider selections to clock generator
   output logic [3:0] periph_clk_en,              // clock enables: ser1, ser0, router, guard
   output logic [3:0] periph_clk,                 // gated peripheral bus clocks
   output logic clock_ready_irq,                  // clock-ready interrupt request
   output logic evt_irq                           // masked sticky event interrupt
);

   // address decode
   wire sel_div = (addr == pm_pkg::DIV_SEL_OFS);
   wire sel_stat = (addr == pm_pkg::EVT_STAT_OFS);
   wire sel_mask = (addr == pm_pkg::EVT_MASK_OFS);
   wire sel_gate = (addr == pm_pkg::BUS_C_MASK_OFS);
   wire sel_en_clr = (addr == pm_pkg::IRQ_EN_CLR_OFS);
   wire sel_en_set = (addr == pm_pkg::IRQ_EN_SET_OFS);
   wire sel_flag = (addr == pm_pkg::IRQ_FLAG_OFS);
   wire sel_origin = (addr == pm_pkg::RESET_ORIGIN_OFS);

   wire wbit0 = wdata[pm_pkg::CLOCK_READY_BIT];
   wire wr_div = wr && sel_div;
   wire wr_gate = wr && sel_gate;
   wire en_clear = wr && sel_en_clr && wbit0;
   wire en_set = wr && sel_en_set && wbit0;
   wire flag_clear = wr && sel_flag && wbit0;
   wire stat_read = rd && sel_stat;

   // state
   logic [3:0] gate_ff;
   logic irq_en_ff;
   logic flag_ff;
   logic [7:0] origin_ff;
   logic origin_done_ff;
   logic [2:0] cpu_sel_ff;
   logic [2:0] bus_sel_ff;
   logic [4:0] settle_ff;
   logic [2:0] evt_stat_ff;
   logic [2:0] evt_mask_ff;
   logic [31:0] rdata_ff;
   pm_pkg::reset_src_t src_meta;
   pm_pkg::reset_src_t src_sync;

   // next values
   logic [3:0] nxt_gate;
   logic nxt_irq_en;
   logic nxt_flag;
   logic [4:0] nxt_settle;
   logic [2:0] nxt_evt_stat;
   logic [31:0] nxt_rdata;
   logic [7:0] src_vec;

   // gate mask register
   assign nxt_gate = wr_gate ? wdata[pm_pkg::GATE_BITS-1:0] : gate_ff;

   // enable set wins over nothing; clear and set never share a cycle
   assign nxt_irq_en = en_clear ? 1'b0 :
                       en_set ? 1'b1 :
                       irq_en_ff;

   // divider settle countdown; each selection write restarts it
   assign nxt_settle = wr_div ? pm_pkg::SETTLE_CNT :
                       (settle_ff != 5'h0) ? settle_ff - 5'h1 : 5'h0;
   wire ready_set = (settle_ff == 5'h1);

   // hardware set wins over a same-cycle software clear
   assign nxt_flag = ready_set ? 1'b1 :
                     flag_clear ? 1'b0 :
                     flag_ff;

   // request withdrawn combinationally as soon as the enable drops
   assign clock_ready_irq = flag_ff && irq_en_ff;

   // reset sources packed into the origin layout
   assign src_vec = {1'b0, src_sync.sys_request, src_sync.watchdog, src_sync.pin,
                     1'b0, src_sync.brownout_io, src_sync.brownout_core,
                     src_sync.power_on};

   // sticky events; a read clears, but a new event in that cycle survives
   wire [2:0] evt_set = {wr_gate && (nxt_gate != gate_ff),
                         !origin_done_ff,
                         ready_set};
   assign nxt_evt_stat = evt_set | (stat_read ? 3'h0 : evt_stat_ff);
   assign evt_irq = |(evt_stat_ff & evt_mask_ff);

   // read mux; unmapped addresses return zero
   always_comb begin
      nxt_rdata = 32'h0;
      if (!rd) begin
         nxt_rdata = 32'h0;
      end else if (sel_div) begin
         nxt_rdata[pm_pkg::CPU_SEL_LSB +: pm_pkg::SEL_W] = cpu_sel_ff;
         nxt_rdata[pm_pkg::BUS_SEL_LSB +: pm_pkg::SEL_W] = bus_sel_ff;
      end else if (sel_stat) begin
         nxt_rdata[pm_pkg::EVT_W-1:0] = evt_stat_ff;
      end else if (sel_mask) begin
         nxt_rdata[pm_pkg::EVT_W-1:0] = evt_mask_ff;
      end else if (sel_gate) begin
         nxt_rdata[pm_pkg::GATE_BITS-1:0] = gate_ff;
      end else if (sel_en_clr || sel_en_set) begin
         nxt_rdata[pm_pkg::CLOCK_READY_BIT] = irq_en_ff;
      end else if (sel_flag) begin
         nxt_rdata[pm_pkg::CLOCK_READY_BIT] = flag_ff;
      end else if (sel_origin) begin
         nxt_rdata[7:0] = origin_ff;
      end
   end

   // reset sources arrive from another domain: two flops, no reset so
   // the levels seen during reset are already settled at the release
   always_ff @(posedge clk) begin
      src_meta <= reset_src;
      src_sync <= src_meta;
   end

   // register file and interrupt logic
   always_ff @(posedge clk) begin
      if (srst) begin
         gate_ff <= pm_pkg::BUS_C_MASK_RST;
         irq_en_ff <= 1'b0;
         flag_ff <= 1'b0;
         settle_ff <= 5'h0;
         cpu_sel_ff <= pm_pkg::SEL_RST;
         bus_sel_ff <= pm_pkg::SEL_RST;
         evt_stat_ff <= pm_pkg::EVT_RST;
         evt_mask_ff <= pm_pkg::EVT_RST;
         rdata_ff <= 32'h0;
      end else begin
         gate_ff <= nxt_gate;
         irq_en_ff <= nxt_irq_en;
         flag_ff <= nxt_flag;
         settle_ff <= nxt_settle;
         evt_stat_ff <= nxt_evt_stat;
         rdata_ff <= nxt_rdata;
         if (wr_div) begin
            cpu_sel_ff <= wdata[pm_pkg::CPU_SEL_LSB +: pm_pkg::SEL_W];
            bus_sel_ff <= wdata[pm_pkg::BUS_SEL_LSB +: pm_pkg::SEL_W];
         end
         if (wr && sel_mask) begin
            evt_mask_ff <= wdata[pm_pkg::EVT_W-1:0];
         end
      end
   end

   // origin capture once, in the first cycle after release; software
   // cannot write it. an empty source vector keeps the power-on value.
   always_ff @(posedge clk) begin
      if (srst) begin
         origin_ff <= pm_pkg::RESET_ORIGIN_RST;
         origin_done_ff <= 1'b0;
      end else begin
         origin_done_ff <= 1'b1;
         if (!origin_done_ff && (src_vec != 8'h0)) begin
            origin_ff <= src_vec;
         end
      end
   end

   // glitch-free gates: the enable is latched while the clock is low
   genvar g;
   generate
      for (g = 0; g < pm_pkg::GATE_BITS; g++) begin : gen_gate
         logic en_lat;
         always_latch begin
            if (!clk) begin
               en_lat = gate_ff[g];
            end
         end
         assign periph_clk[g] = clk && en_lat;
      end
   endgenerate

   assign periph_clk_en = gate_ff;
   assign rdata = rdata_ff;
   assign div_sel.cpu_clock_divider_sel = cpu_sel_ff;
   assign div_sel.bus_clock_divider_sel = bus_sel_ff;

   // checks
   localparam int AST_SETTLE_MAX = pm_pkg::SETTLE_CYC + 1;

   // cycles since the last divider selection write, for the settle timing check;
   // it saturates so a long idle spell cannot wrap it back into range
   logic [4:0] since_div_ff;
   always_ff @(posedge clk) begin
      if (srst) begin
         since_div_ff <= 5'h0;
      end else if (wr_div) begin
         since_div_ff <= 5'h0;
      end else if (since_div_ff != 5'h1f) begin
         since_div_ff <= since_div_ff + 5'h1;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   AST_GATE_WRITE: assert property (
      wr_gate |=> periph_clk_en == $past(wdata[3:0]))
      else $error("gate mask not taken from write");

   AST_EN_CLEAR: assert property (
      en_clear |=> !irq_en_ff && !clock_ready_irq)
      else $error("enable clear left request active");

   AST_EN_SET: assert property (
      en_set |=> irq_en_ff)
      else $error("enable set did not enable");

   AST_ZERO_WRITE: assert property (
      (wr && (sel_en_clr || sel_en_set || sel_flag) && !wbit0 && !ready_set)
      |=> (irq_en_ff == $past(irq_en_ff)) && (flag_ff == $past(flag_ff)))
      else $error("zero write changed state");

   AST_IRQ_GATE: assert property (
      (!irq_en_ff |-> !clock_ready_irq) and (flag_ff && irq_en_ff |-> clock_ready_irq))
      else $error("request does not follow flag and enable");

   AST_READY_SET: assert property (
      wr_div ##1 (!wr_div && !flag_clear)[*1] |-> ##[1:AST_SETTLE_MAX] flag_ff)
      else $error("clock ready flag not set after settling");

   AST_FLAG_CLEAR: assert property (
      (flag_clear && !ready_set) |=> !flag_ff)
      else $error("flag not cleared by write one");

   AST_ORIGIN_RESET: assert property (
      disable iff (1'b0) srst |=> origin_ff == pm_pkg::RESET_ORIGIN_RST)
      else $error("reset origin reset value wrong");

   AST_ORIGIN_SYS: assert property (
      (!origin_done_ff && src_sync.sys_request) |=> origin_ff[6])
      else $error("system request cause lost");

   AST_ORIGIN_WDOG: assert property (
      (!origin_done_ff && src_sync.watchdog) |=> origin_ff[5])
      else $error("watchdog cause lost");

   AST_ORIGIN_PIN: assert property (
      (!origin_done_ff && src_sync.pin) |=> origin_ff[4])
      else $error("pin cause lost");

   AST_ORIGIN_BOD_IO: assert property (
      (!origin_done_ff && src_sync.brownout_io) |=> origin_ff[2])
      else $error("io brown-out cause lost");

   AST_ORIGIN_BOD_CORE: assert property (
      (!origin_done_ff && src_sync.brownout_core) |=> origin_ff[1])
      else $error("core brown-out cause lost");

   AST_ORIGIN_STABLE: assert property (
      origin_done_ff |=> $stable(origin_ff))
      else $error("reset origin changed after capture");

   AST_EN_READBACK: assert property (
      (rd && (sel_en_clr || sel_en_set)) |=> rdata == {31'h0, $past(irq_en_ff)})
      else $error("enable readback mismatch");

   // register bus answers and holds between writes
   AST_RDATA_IDLE: assert property (
      !rd |=> rdata == 32'h0)
      else $error("read data not zero outside the answer cycle");

   AST_GATE_HOLD: assert property (
      !wr_gate |=> $stable(periph_clk_en))
      else $error("gate mask changed without a write");

   AST_GATE_READBACK: assert property (
      (rd && sel_gate) |=> rdata == {28'h0, $past(gate_ff)})
      else $error("gate mask readback mismatch");

   AST_EN_HOLD: assert property (
      (!en_clear && !en_set) |=> $stable(irq_en_ff))
      else $error("enable changed without a write of one");

   AST_IRQ_EN_ON: assert property (
      (flag_ff && en_set) |=> clock_ready_irq)
      else $error("enable set with flag up gave no request");

   AST_IRQ_NO_FLAG: assert property (
      !flag_ff |-> !clock_ready_irq)
      else $error("request without clock ready flag");

   AST_FLAG_HOLD: assert property (
      (!ready_set && !flag_clear) |=> $stable(flag_ff))
      else $error("flag changed without set or clear");

   AST_FLAG_SET_WINS: assert property (
      ready_set |=> flag_ff)
      else $error("clock ready set lost");

   AST_FLAG_READBACK: assert property (
      (rd && sel_flag) |=> rdata == {31'h0, $past(flag_ff)})
      else $error("flag readback mismatch");

   AST_SETTLE_LOAD: assert property (
      wr_div |=> settle_ff == pm_pkg::SETTLE_CNT)
      else $error("settle count not loaded by selection write");

   AST_READY_EXACT: assert property (
      ($rose(flag_ff) && !$past(wr_div)) |-> since_div_ff == pm_pkg::SETTLE_CNT)
      else $error("clock ready flag set off the settle count");

   AST_DIV_WRITE: assert property (
      wr_div |=> div_sel == $past({wdata[pm_pkg::BUS_SEL_LSB +: pm_pkg::SEL_W],
                                   wdata[pm_pkg::CPU_SEL_LSB +: pm_pkg::SEL_W]}))
      else $error("divider selection not taken from write");

   // origin capture
   AST_ORIGIN_POR: assert property (
      (!origin_done_ff && src_sync.power_on) |=> origin_ff[0])
      else $error("power-on cause lost");

   AST_ORIGIN_EMPTY: assert property (
      (!origin_done_ff && (src_vec == 8'h0)) |=> origin_ff == pm_pkg::RESET_ORIGIN_RST)
      else $error("empty cause vector changed reset origin");

   AST_ORIGIN_WRITE_IGNORED: assert property (
      (origin_done_ff && wr && sel_origin) |=> $stable(origin_ff))
      else $error("reset origin took a write");

   AST_ORIGIN_READBACK: assert property (
      (rd && sel_origin) |=> rdata == {24'h0, $past(origin_ff)})
      else $error("reset origin readback mismatch");

   // event status
   AST_EVT_READY: assert property (
      ready_set |=> evt_stat_ff[pm_pkg::EVT_CLOCK_READY])
      else $error("clock ready event not recorded");

   AST_EVT_ORIGIN: assert property (
      !origin_done_ff |=> evt_stat_ff[pm_pkg::EVT_ORIGIN_CAPTURED])
      else $error("origin captured event not recorded");

   AST_EVT_GATE: assert property (
      (wr_gate && (wdata[3:0] != gate_ff)) |=> evt_stat_ff[pm_pkg::EVT_GATE_CHANGED])
      else $error("gate change event not recorded");

   AST_EVT_STICKY: assert property (
      !stat_read |=> (evt_stat_ff & $past(evt_stat_ff)) == $past(evt_stat_ff))
      else $error("event bit dropped without a read");

   AST_EVT_CLEAR: assert property (
      (stat_read && (evt_set == 3'h0)) |=> evt_stat_ff == 3'h0)
      else $error("event status not cleared by read");

   AST_MASK_WRITE: assert property (
      (wr && sel_mask) |=> evt_mask_ff == $past(wdata[pm_pkg::EVT_W-1:0]))
      else $error("event mask not taken from write");

   COV_READY_IRQ: cover property (wr_div ##[1:AST_SETTLE_MAX] clock_ready_irq);
   COV_SET_CLEAR_CLASH: cover property (ready_set && flag_clear);
   COV_GATE_ON: cover property (wr_gate ##1 periph_clk_en == 4'hf);
   COV_EVT_IRQ: cover property (evt_irq ##1 stat_read);
   COV_ORIGIN_WDOG: cover property (!origin_done_ff && src_sync.watchdog);

endmodule // pm_clock_gate_irq_reset_cause

// [pm_clock_gate_irq_reset_cause_tb_top.sv]
// self-checking testbench for the clock gate, clock-ready interrupt and reset origin block
module pm_clock_gate_irq_reset_cause_tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk = 1'b0;
   logic srst = 1'b1;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic [31:0] v;
   logic [5:0] src;
   pm_pkg::reset_src_t reset_src = 6'h01;
   pm_pkg::div_sel_t div_sel;
   logic [3:0] periph_clk_en;
   logic [3:0] periph_clk;
   logic clock_ready_irq;
   logic evt_irq;
   int num_errors = 0;
   int checks_done = 0;

   // 250 MHz bus clock
   always #2 clk = ~clk;

   pm_clock_gate_irq_reset_cause u_dut (
      .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .reset_src(reset_src), .div_sel(div_sel), .periph_clk_en(periph_clk_en),
      .periph_clk(periph_clk), .clock_ready_irq(clock_ready_irq), .evt_irq(evt_irq)
   );

   // compare and count, report at once on a difference
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up();
      $display("checks=%0d mismatches=%0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // one-cycle write; a new strobe never lands on the edge that drops the last one
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // read data stands only in the cycle after the strobe, so sample just past that edge
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask

   // reset causes held well past release so the two-flop sync sees them
   task automatic do_reset(input logic [5:0] s);
      @(posedge clk);
      srst <= 1'b1;
      reset_src <= s;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      repeat (4) @(posedge clk);
   endtask

   initial begin
      // power-on: reset held two edges with only the power-on cause up
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      repeat (4) @(posedge clk);
      rd_reg(pm_pkg::RESET_ORIGIN_OFS, v); check(v, 32'h01);
      @(posedge clk);
      #1; check(rdata, 32'h0);
      foreach (v[i]) begin
         if (i < 3) begin
            rd_reg(pm_pkg::IRQ_EN_CLR_OFS + 8'(i), v); check(v, 32'h0);
         end
      end
      rd_reg(8'h3c, v); check(v, 32'h0);
      // origin-captured event, masked then unmasked, cleared by reading
      check({31'h0, evt_irq}, 32'h0);
      wr_reg(pm_pkg::EVT_MASK_OFS, 32'h02);
      #1; check({31'h0, evt_irq}, 32'h1);
      rd_reg(pm_pkg::EVT_STAT_OFS, v); check(v, 32'h02);
      #1; check({31'h0, evt_irq}, 32'h0);
      rd_reg(pm_pkg::EVT_MASK_OFS, v); check(v, 32'h02);
      $display("test reset and events done");

      // each gate bit alone; upper bits are not stored
      for (int i = 0; i < 4; i++) begin
         wr_reg(pm_pkg::BUS_C_MASK_OFS, 32'hf0 | (32'h1 << i));
         @(posedge clk);
         #1; check({28'h0, periph_clk_en}, 32'h1 << i);
         check({28'h0, periph_clk}, 32'h1 << i);
         rd_reg(pm_pkg::BUS_C_MASK_OFS, v); check(v, 32'h1 << i);
      end
      rd_reg(pm_pkg::EVT_STAT_OFS, v); check(v, 32'h04);
      $display("test clock gates done");

      // enable: zero write ignored, one sets, both views read back
      wr_reg(pm_pkg::IRQ_EN_SET_OFS, 32'hfe);
      rd_reg(pm_pkg::IRQ_EN_SET_OFS, v); check(v, 32'h0);
      wr_reg(pm_pkg::IRQ_EN_SET_OFS, 32'h01);
      rd_reg(pm_pkg::IRQ_EN_CLR_OFS, v); check(v, 32'h1);
      rd_reg(pm_pkg::IRQ_EN_SET_OFS, v); check(v, 32'h1);
      // new divider selection, flag rises after the settling count
      wr_reg(pm_pkg::DIV_SEL_OFS, 32'h31);
      #1; check({26'h0, div_sel}, 32'h19);
      repeat (9) @(posedge clk);
      #1; check({31'h0, clock_ready_irq}, 32'h0);
      @(posedge clk);
      #1; check({31'h0, clock_ready_irq}, 32'h1);
      rd_reg(pm_pkg::EVT_STAT_OFS, v); check(v, 32'h01);
      rd_reg(pm_pkg::DIV_SEL_OFS, v); check(v, 32'h31);
      rd_reg(pm_pkg::IRQ_FLAG_OFS, v); check(v, 32'h1);
      wr_reg(pm_pkg::IRQ_EN_CLR_OFS, 32'h0);
      #1; check({31'h0, clock_ready_irq}, 32'h1);
      wr_reg(pm_pkg::IRQ_FLAG_OFS, 32'h0);
      rd_reg(pm_pkg::IRQ_FLAG_OFS, v); check(v, 32'h1);
      wr_reg(pm_pkg::IRQ_EN_CLR_OFS, 32'h1);
      #1; check({31'h0, clock_ready_irq}, 32'h0);
      rd_reg(pm_pkg::IRQ_EN_SET_OFS, v); check(v, 32'h0);
      wr_reg(pm_pkg::IRQ_EN_SET_OFS, 32'h1);
      #1; check({31'h0, clock_ready_irq}, 32'h1);
      wr_reg(pm_pkg::IRQ_EN_CLR_OFS, 32'h1);
      #1; check({31'h0, clock_ready_irq}, 32'h0);
      wr_reg(pm_pkg::IRQ_FLAG_OFS, 32'h1);
      rd_reg(pm_pkg::IRQ_FLAG_OFS, v); check(v, 32'h0);
      $display("test clock ready interrupt done");

      // every cause beside power-on; origin is read-only
      for (int i = 1; i < 6; i++) begin
         src = 6'h01 | (6'h01 << i);
         do_reset(src);
         wr_reg(pm_pkg::RESET_ORIGIN_OFS, 32'hff);
         rd_reg(pm_pkg::RESET_ORIGIN_OFS, v);
         check(v, {24'h0, 1'b0, src[5:3], 1'b0, src[2:0]});
      end
      // no cause reported at all keeps the power-on value
      do_reset(6'h00);
      rd_reg(pm_pkg::RESET_ORIGIN_OFS, v); check(v, 32'h01);
      check({28'h0, periph_clk_en}, 32'h0);
      $display("test reset origin done");
      wrap_up();
   end

   // watchdog sized well above the roughly 155 cycles the tests need
   initial begin
      repeat (3000) @(posedge clk);
      num_errors++;
      wrap_up();
   end
endmodule // pm_clock_gate_irq_reset_cause_tb_top
